// ---- can_cfg_pkg.sv ----
package can_cfg_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_TIMING = 8'h00;
   localparam logic [7:0] OFS_FLT_EN = 8'h04;
   localparam logic [7:0] OFS_PTR_LOW = 8'h08;
   localparam logic [7:0] OFS_PRESCALE = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int POS_WAKE_FILTER = 14;
   localparam int POS_PH2_LEN = 8;
   localparam int POS_PH2_SEL = 7;
   localparam int POS_TRIPLE = 6;
   localparam int POS_PH1_LEN = 3;
   localparam int POS_PROP_LEN = 0;
   localparam int PTR_WIDTH = 4;
   // writable bits of the timing register: 14, 10-0
   localparam logic [15:0] TIMING_MASK = 16'h47ff;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RST_TIMING = 16'h0000;
   localparam logic [15:0] RST_FLT_EN = 16'h003f;
   localparam logic [15:0] RST_PTR_LOW = 16'h0000;
   localparam logic [5:0] RST_PRESCALE = 6'h00;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int WAKE_FILTER_NS = 100;
   // least time, rounded up
   localparam int WAKE_FILTER_CYCLES = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // information processing time in quanta, as a length field value
   localparam logic [2:0] INFO_PROCESSING_TIME_FIELD = 3'h1;
   typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} seg_state_t;
endpackage

// ---- can_line_sampler.sv ----
`timescale 1ns/10ps
module can_line_sampler
   import can_cfg_pkg::*;
#(
   parameter int FILTER_CYCLES = WAKE_FILTER_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rx_pin,
   input wire logic sample_point,
   input wire logic triple_sample_select,
   input wire logic wake_line_filter_select,
   output logic bit_value,
   output logic wake_event
);
   logic sync_a;
   logic sync_b;
   logic [2:0] hist;
   logic filtered;
   logic [7:0] stable_cnt;
   logic wake_src;
   logic wake_prev;

   // ------------------------------------------------------------
   // pin synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
      end
      else
      begin
         sync_a <= rx_pin;
         sync_b <= sync_a;
      end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         hist <= 3'h7;
      else
         hist <= {hist[1:0], sync_b};

   // ------------------------------------------------------------
   // sampling at the sample point
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         bit_value <= 1'b1;
      else if (sample_point)
      begin
         if (triple_sample_select)
            bit_value <= (hist[0] & hist[1]) | (hist[0] & hist[2]) | (hist[1] & hist[2]);
         else
            bit_value <= hist[0];
      end

   // ------------------------------------------------------------
   // line filter: level must hold a while before it counts
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         stable_cnt <= 8'h00;
         filtered <= 1'b1;
      end
      else if (hist[0] == filtered)
         stable_cnt <= 8'h00;
      else if (stable_cnt >= 8'(FILTER_CYCLES - 1))
      begin
         filtered <= hist[0];
         stable_cnt <= 8'h00;
      end
      else
         stable_cnt <= stable_cnt + 8'h01;

   // glitches shorter than the filter time never wake when filtered
   assign wake_src = wake_line_filter_select ? filtered : hist[0];

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         wake_prev <= 1'b1;
      else
         wake_prev <= wake_src;

   assign wake_event = wake_prev & ~wake_src;
endmodule // can_line_sampler

// ---- can_bit_timing_filter_routing.sv ----
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/10ps
module can_bit_timing_filter_routing
   import can_cfg_pkg::*;
#(
   parameter int FILTER_COUNT = 16,
   parameter int FILTER_CYCLES = WAKE_FILTER_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_pin,
   input wire logic [FILTER_COUNT-1:0] filter_hit,
   input wire logic hit_valid,
   output logic [FILTER_COUNT-1:0] enabled_hit,
   output logic store_valid,
   output logic [PTR_WIDTH-1:0] store_buffer,
   output logic sample_point,
   output logic bit_end,
   output logic bit_value,
   output logic wake_event
);
   logic [15:0] bit_timing_config_two;
   logic [15:0] filter_enable;
   logic [15:0] filter_buffer_pointer_low;
   logic [5:0] quantum_prescaler;
   logic [6:0] tq_cnt;
   logic tq_tick;
   seg_state_t state;
   logic [2:0] seg_cnt;
   logic [2:0] ph2_eff;
   logic [2:0] seg_last;
   logic mapped;
   logic wr_en;
   logic [31:0] next_rdata;
   logic [4:0] bit_tq;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [2:0] field3(input logic [15:0] r, input int pos);
      field3 = r[pos +: 3];
   endfunction

   function automatic logic [2:0] max3(input logic [2:0] a, input logic [2:0] b);
      max3 = (a > b) ? a : b;
   endfunction

   // ------------------------------------------------------------
   // apb slave, zero wait states
   // ------------------------------------------------------------
   assign pready = 1'b1;
   assign mapped = (paddr == OFS_TIMING) || (paddr == OFS_FLT_EN) ||
      (paddr == OFS_PTR_LOW) || (paddr == OFS_PRESCALE) || (paddr == OFS_STATUS);
   assign pslverr = psel & penable & ~mapped;
   assign wr_en = psel & penable & pwrite & mapped;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         bit_timing_config_two <= RST_TIMING;
      else if (wr_en && paddr == OFS_TIMING)
         bit_timing_config_two <= pwdata[15:0] & TIMING_MASK;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         filter_enable <= RST_FLT_EN;
      else if (wr_en && paddr == OFS_FLT_EN)
         filter_enable <= pwdata[15:0];

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         filter_buffer_pointer_low <= RST_PTR_LOW;
      else if (wr_en && paddr == OFS_PTR_LOW)
         filter_buffer_pointer_low <= pwdata[15:0];

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         quantum_prescaler <= RST_PRESCALE;
      else if (wr_en && paddr == OFS_PRESCALE)
         quantum_prescaler <= pwdata[5:0];

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      case (paddr)
         OFS_TIMING: next_rdata[15:0] = bit_timing_config_two;
         OFS_FLT_EN: next_rdata[15:0] = filter_enable;
         OFS_PTR_LOW: next_rdata[15:0] = filter_buffer_pointer_low;
         OFS_PRESCALE: next_rdata[5:0] = quantum_prescaler;
         OFS_STATUS: next_rdata = {16'h0000, 5'h00, ph2_eff, 2'h0, bit_tq, bit_value};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // read data latched in the setup cycle, stable through access
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= next_rdata;

   // ------------------------------------------------------------
   // time quantum
   // ------------------------------------------------------------
   assign tq_tick = (tq_cnt == {quantum_prescaler, 1'b1});

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         tq_cnt <= 7'h00;
      else if (tq_tick || tq_cnt > {quantum_prescaler, 1'b1})
         tq_cnt <= 7'h00;
      else
         tq_cnt <= tq_cnt + 7'h01;

   // ------------------------------------------------------------
   // bit segments
   // ------------------------------------------------------------
   // with the ph2 select bit clear, ph2 follows the greater of phase one and the processing time live; a change mid bit takes effect at once
   assign ph2_eff = bit_timing_config_two[POS_PH2_SEL] ?
      field3(bit_timing_config_two, POS_PH2_LEN) :
      max3(field3(bit_timing_config_two, POS_PH1_LEN), INFO_PROCESSING_TIME_FIELD);

   assign bit_tq = 5'h04 + 5'(field3(bit_timing_config_two, POS_PROP_LEN)) +
      5'(field3(bit_timing_config_two, POS_PH1_LEN)) + 5'(ph2_eff);

   always_comb
   begin
      case (state)
         SEG_PROP: seg_last = field3(bit_timing_config_two, POS_PROP_LEN);
         SEG_PH1: seg_last = field3(bit_timing_config_two, POS_PH1_LEN);
         SEG_PH2: seg_last = ph2_eff;
         default: seg_last = 3'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         state <= SEG_SYNC;
         seg_cnt <= 3'h0;
      end
      else if (tq_tick)
      begin
         if (seg_cnt >= seg_last)
         begin
            seg_cnt <= 3'h0;
            case (state)
               SEG_SYNC: state <= SEG_PROP;
               SEG_PROP: state <= SEG_PH1;
               SEG_PH1: state <= SEG_PH2;
               SEG_PH2: state <= SEG_SYNC;
               default: state <= SEG_SYNC;
            endcase
         end
         else
            seg_cnt <= seg_cnt + 3'h1;
      end

   assign sample_point = tq_tick && state == SEG_PH1 && seg_cnt >= seg_last;
   assign bit_end = tq_tick && state == SEG_PH2 && seg_cnt >= seg_last;

   can_line_sampler #(
      .FILTER_CYCLES(FILTER_CYCLES)
   ) u_sampler (
      .pclk(pclk),
      .presetn(presetn),
      .rx_pin(rx_pin),
      .sample_point(sample_point),
      .triple_sample_select(bit_timing_config_two[POS_TRIPLE]),
      .wake_line_filter_select(bit_timing_config_two[POS_WAKE_FILTER]),
      .bit_value(bit_value),
      .wake_event(wake_event)
   );

   // ------------------------------------------------------------
   // acceptance gating and routing
   // ------------------------------------------------------------
   // only filters zero to three carry a pointer here; lowest wins
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         enabled_hit <= '0;
         store_valid <= 1'b0;
         store_buffer <= '0;
      end
      else
      begin
         enabled_hit <= hit_valid ? (filter_hit & filter_enable[FILTER_COUNT-1:0]) : '0;
         store_valid <= hit_valid && |(filter_hit[3:0] & filter_enable[3:0]);
         if (hit_valid)
         begin
            if (filter_hit[0] && filter_enable[0])
               store_buffer <= filter_buffer_pointer_low[3:0];
            else if (filter_hit[1] && filter_enable[1])
               store_buffer <= filter_buffer_pointer_low[7:4];
            else if (filter_hit[2] && filter_enable[2])
               store_buffer <= filter_buffer_pointer_low[11:8];
            else if (filter_hit[3] && filter_enable[3])
               store_buffer <= filter_buffer_pointer_low[15:12];
         end
      end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_reserved_bits_zero: assert property (
      (bit_timing_config_two & ~TIMING_MASK) == 16'h0000)
      else $error("timing reserved bits not zero");
   a_tq_period: assert property (
      tq_tick && $stable(quantum_prescaler) |=> !tq_tick [*1] ##0
      (tq_cnt == 7'h00))
      else $error("quantum counter did not restart");
   a_tq_count_bound: assert property (
      tq_cnt <= {quantum_prescaler, 1'b1} || $changed(quantum_prescaler) ||
      $past(quantum_prescaler) != quantum_prescaler)
      else $error("quantum counter beyond prescaler");
   a_ph2_select_free: assert property (
      bit_timing_config_two[POS_PH2_SEL] |->
      ph2_eff == bit_timing_config_two[POS_PH2_LEN +: 3])
      else $error("programmed phase two not used");
   a_ph2_select_auto: assert property (
      !bit_timing_config_two[POS_PH2_SEL] |->
      ph2_eff >= bit_timing_config_two[POS_PH1_LEN +: 3] && ph2_eff >= INFO_PROCESSING_TIME_FIELD)
      else $error("automatic phase two too short");
   a_sample_after_ph1: assert property (
      sample_point |=> state == SEG_PH2 && seg_cnt == 3'h0)
      else $error("sample point not at end of phase one");
   a_sync_one_tq: assert property (
      tq_tick && state == SEG_SYNC |=> state == SEG_PROP)
      else $error("sync segment longer than one quantum");
   a_prop_length: assert property (
      tq_tick && state == SEG_PROP && seg_cnt < bit_timing_config_two[2:0] &&
      $stable(bit_timing_config_two) |=> state == SEG_PROP)
      else $error("propagation segment ended early");
   a_ph1_length: assert property (
      tq_tick && state == SEG_PH1 && seg_cnt < bit_timing_config_two[POS_PH1_LEN +: 3] |=>
      state == SEG_PH1)
      else $error("phase one segment ended early");
   a_ph2_length: assert property (
      tq_tick && state == SEG_PH2 && seg_cnt < ph2_eff |=> state == SEG_PH2)
      else $error("phase two segment ended early");
   a_bit_wraps: assert property (
      bit_end |=> state == SEG_SYNC && seg_cnt == 3'h0)
      else $error("bit did not restart at sync");
   // segments move only on a quantum tick, else the bit time drifts
   a_hold_between_ticks: assert property (
      !tq_tick |=> state == $past(state) && seg_cnt == $past(seg_cnt))
      else $error("segment moved without a quantum tick");
   a_seg_count_step: assert property (
      tq_tick && seg_cnt < seg_last |=> seg_cnt == $past(seg_cnt) + 3'h1)
      else $error("segment counter skipped");

   // ------------------------------------------------------------
   // filter checks
   // ------------------------------------------------------------
   a_disabled_no_hit: assert property (
      hit_valid && !(filter_hit[0] && filter_enable[0]) && !(filter_hit[1] && filter_enable[1]) &&
      !(filter_hit[2] && filter_enable[2]) && !(filter_hit[3] && filter_enable[3])
      |=> !store_valid)
      else $error("disabled filter caused a store");
   a_route_filter0: assert property (
      hit_valid && filter_hit[0] && filter_enable[0] |=>
      store_valid && store_buffer == $past(filter_buffer_pointer_low[3:0]))
      else $error("filter zero routed to wrong buffer");
   a_enable_gates: assert property (
      ##1 (enabled_hit & ~$past(filter_enable[FILTER_COUNT-1:0])) == '0)
      else $error("enabled hit from disabled filter");
   a_route_filter1: assert property (
      hit_valid && !(filter_hit[0] && filter_enable[0]) && filter_hit[1] && filter_enable[1]
      |=> store_valid && store_buffer == $past(filter_buffer_pointer_low[7:4]))
      else $error("filter one routed to wrong buffer");
   a_route_filter2: assert property (
      hit_valid && !(|(filter_hit[1:0] & filter_enable[1:0])) && filter_hit[2] &&
      filter_enable[2] |=> store_valid &&
      store_buffer == $past(filter_buffer_pointer_low[11:8]))
      else $error("filter two routed to wrong buffer");
   a_route_filter3: assert property (
      hit_valid && !(|(filter_hit[2:0] & filter_enable[2:0])) && filter_hit[3] &&
      filter_enable[3] |=> store_valid &&
      store_buffer == $past(filter_buffer_pointer_low[15:12]))
      else $error("filter three routed to wrong buffer");
   a_idle_no_store: assert property (
      !hit_valid |=> enabled_hit == '0 && !store_valid)
      else $error("store without a qualified hit");
   a_store_needs_hit: assert property (
      store_valid |-> $past(hit_valid))
      else $error("store pulse without hit valid");

   // ------------------------------------------------------------
   // coverage
   // ------------------------------------------------------------
   c_store: cover property (hit_valid ##1 store_valid);
   c_filtered_wake: cover property (wake_event && bit_timing_config_two[POS_WAKE_FILTER]);
   c_wake: cover property (wake_event);
   c_triple: cover property (sample_point && bit_timing_config_two[POS_TRIPLE]);
   c_bit: cover property (bit_end);
endmodule // can_bit_timing_filter_routing

// ---- can_bus_node.sv ----
`timescale 1ns/10ps
module can_bus_node
(
   input wire logic pclk,
   output logic rx_pin
);
   // ----------------------------------------
   // far-side node, recessive when idle
   // ----------------------------------------
   initial rx_pin = 1'b1;
   // dominant for n clocks; a one-clock call makes a glitch
   task automatic drive_dominant(input int n);
      @(posedge pclk);
      rx_pin <= 1'b0;
      repeat (n) @(posedge pclk);
      rx_pin <= 1'b1;
   endtask
endmodule // can_bus_node

// ---- can_bit_timing_filter_routing_tb.sv ----
`timescale 1ns/10ps
module can_bit_timing_filter_routing_tb;
   import can_cfg_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_pin, hit_valid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] filter_hit, enabled_hit;
   logic store_valid, sample_point, bit_end, bit_value, wake_event, err;
   logic [PTR_WIDTH-1:0] store_buffer;
   int n_fail = 0, checked = 0, n_zero = 0, n_wake = 0;
   // ----------------------------------------
   // clock, design, far side
   // ----------------------------------------
   initial pclk = 1'b0;
   always #12.5 pclk = ~pclk;
   can_bit_timing_filter_routing #(.FILTER_COUNT(16), .FILTER_CYCLES(2)) uut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
      .filter_hit(filter_hit), .hit_valid(hit_valid), .enabled_hit(enabled_hit),
      .store_valid(store_valid), .store_buffer(store_buffer), .sample_point(sample_point),
      .bit_end(bit_end), .bit_value(bit_value), .wake_event(wake_event));
   can_bus_node node (.pclk(pclk), .rx_pin(rx_pin));
   always @(posedge pclk)
   begin
      if (bit_value === 1'b0) n_zero++;
      if (wake_event === 1'b1) n_wake++;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 64);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 64) check("pready", 0, 1);
   endtask
   task automatic hit(input logic [15:0] f, input logic v, input logic [3:0] b,
                      input logic [15:0] e);
      @(posedge pclk);
      filter_hit <= f;
      hit_valid <= 1'b1;
      @(posedge pclk);
      filter_hit <= 16'h0000;
      hit_valid <= 1'b0;
      #1;
      check("store_valid", 32'(store_valid), 32'(v));
      check("store_buffer", 32'(store_buffer), 32'(b));
      check("enabled_hit", 32'(enabled_hit), 32'(e));
   endtask
   // edges from the last pulse until the chosen pulse
   task automatic gap(input bit sp, output int n);
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while ((sp ? sample_point : bit_end) !== 1'b1 && n < 2000);
   endtask
   // one-clock glitches stepping one clock per bit across the bit
   task automatic sweep(output int zeros, output int wakes);
      int z0, w0;
      z0 = n_zero;
      w0 = n_wake;
      repeat (16)
      begin
         node.drive_dominant(1);
         repeat (7) @(posedge pclk);
      end
      repeat (20) @(posedge pclk);
      #1;
      zeros = n_zero - z0;
      wakes = n_wake - w0;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_regs;
      apb(OFS_TIMING, 1'b0, 32'h0);
      check("timing reset", rd, 32'(RST_TIMING));
      apb(OFS_PRESCALE, 1'b0, 32'h0);
      check("prescaler reset", rd, 32'(RST_PRESCALE));
      apb(OFS_PRESCALE, 1'b1, 32'hffffffff);
      apb(OFS_PRESCALE, 1'b0, 32'h0);
      check("prescaler width", rd, 32'h0000003f);
      apb(OFS_FLT_EN, 1'b0, 32'h0);
      check("enable reset", rd, 32'(RST_FLT_EN));
      apb(OFS_PTR_LOW, 1'b0, 32'h0);
      check("pointer reset", rd, 32'(RST_PTR_LOW));
      apb(OFS_TIMING, 1'b1, 32'hffffffff);
      apb(OFS_TIMING, 1'b0, 32'h0);
      check("timing unused bits", rd, 32'h000047ff);
      apb(OFS_FLT_EN, 1'b1, 32'h0000a5c3);
      apb(OFS_FLT_EN, 1'b0, 32'h0);
      check("enable readback", rd, 32'h0000a5c3);
      apb(8'h14, 1'b0, 32'h0);
      check("unmapped error", 32'(err), 32'h1);
      check("unmapped data", rd, 32'h0);
      $display("register test done");
   endtask
   task automatic test_filters;
      apb(OFS_FLT_EN, 1'b1, 32'h0000002f);
      apb(OFS_PTR_LOW, 1'b1, 32'h0000f90a);
      for (int i = 0; i < 4; i++)
         hit(16'(1 << i), 1'b1, 4'(32'hf90a >> (4 * i)), 16'(1 << i));
      apb(OFS_FLT_EN, 1'b1, 32'h0000002b);
      hit(16'h0004, 1'b0, 4'hf, 16'h0000);
      hit(16'h0020, 1'b0, 4'hf, 16'h0020);
      hit(16'h000e, 1'b1, 4'h0, 16'h000a);
      $display("filter test done");
   endtask
   task automatic test_timing;
      int cp[4] = '{0, 1, 0, 2};
      int cprop[4] = '{0, 7, 1, 2};
      int c1[4] = '{0, 2, 0, 5};
      int c2[4] = '{0, 7, 3, 0};
      int cs[4] = '{1, 1, 0, 0};
      int pre, post, tq, e2, st;
      for (int i = 0; i < 4; i++)
      begin
         apb(OFS_PRESCALE, 1'b1, 32'(cp[i]));
         apb(OFS_TIMING, 1'b1, 32'((c2[i] << 8) | (cs[i] << 7) | (c1[i] << 3) | cprop[i]));
         gap(1'b0, pre);
         gap(1'b0, pre);
         gap(1'b1, pre);
         gap(1'b0, post);
         tq = 2 * (cp[i] + 1);
         e2 = cs[i] ? c2[i] + 1 : ((c1[i] > 1) ? c1[i] : 1) + 1;
         check("sample offset", 32'(pre), 32'((3 + cprop[i] + c1[i]) * tq));
         check("phase two", 32'(post), 32'(e2 * tq));
         // status: bit 0 line idle, bits 5:1 bit time in quanta, bits 10:8 phase two field
         st = ((e2 - 1) << 8) | ((3 + cprop[i] + c1[i] + e2) << 1) | 1;
         apb(OFS_STATUS, 1'b0, 32'h0);
         check("status", rd, 32'(st));
      end
      $display("timing test done");
   endtask
   task automatic test_sampling;
      int z, w;
      apb(OFS_PRESCALE, 1'b1, 32'h0);
      apb(OFS_TIMING, 1'b1, 32'h000040c0);
      sweep(z, w);
      check("triple glitch", 32'(z), 32'h0);
      check("filtered wake", 32'(w), 32'h0);
      apb(OFS_TIMING, 1'b1, 32'h00000080);
      sweep(z, w);
      check("single glitch", 32'(z > 0), 32'h1);
      check("raw wake", 32'(w), 32'd16);
      apb(OFS_TIMING, 1'b1, 32'h000040c0);
      sweep(z, w);
      check("triple glitch again", 32'(z), 32'h0);
      check("filtered wake again", 32'(w), 32'h0);
      z = n_zero;
      w = n_wake;
      node.drive_dominant(20);
      repeat (20) @(posedge pclk);
      #1;
      check("long dominant bit", 32'(n_zero > z), 32'h1);
      check("filtered long wake", 32'(n_wake - w), 32'h1);
      $display("sampling test done");
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, hit_valid} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      filter_hit = 16'h0000;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      test_regs();
      test_filters();
      test_timing();
      test_sampling();
      final_report();
   end
   initial
   begin
      #(25 * 20000);
      n_fail++;
      final_report();
   end
endmodule // can_bit_timing_filter_routing_tb
